// >>> hdl/spc_pkg.sv
// Package with offsets, bit positions and reset values of the port registers
//----------------------------------------------------------------------------
//----------------------------------------------------------------------------
package spc_pkg;

  //--------------------------------------------------------------------------
  // Register byte offsets on the bus
  //--------------------------------------------------------------------------
  localparam logic [7:0] SPC_OFF_TXCS = 8'h00;
  localparam logic [7:0] SPC_OFF_RXCS = 8'h04;
  localparam logic [7:0] SPC_OFF_BC   = 8'h08;
  localparam logic [7:0] SPC_OFF_RDAT = 8'h0C;
  localparam logic [7:0] SPC_OFF_DIVL = 8'h10;
  localparam logic [7:0] SPC_OFF_DIVH = 8'h14;
  localparam logic [7:0] SPC_OFF_STAT = 8'h18;

  //--------------------------------------------------------------------------
  // Field positions
  //--------------------------------------------------------------------------
  localparam int TX_CLKSRC  = 7;
  localparam int TX_NINE    = 6;
  localparam int TX_EN      = 5;
  localparam int TX_SYNC    = 4;
  localparam int TX_BRK     = 3;
  localparam int TX_HIBAUD  = 2;
  localparam int TX_EMPTY   = 1;
  localparam int TX_D9      = 0;
  localparam int RX_PORT_EN = 7;
  localparam int RX_NINE    = 6;
  localparam int RX_SINGLE  = 5;
  localparam int RX_CONT    = 4;
  localparam int RX_ADEN    = 3;
  localparam int BC_POL     = 4;
  localparam int BC_WIDE    = 3;
  localparam int BC_WAKE    = 1;
  localparam int BC_ABD  = 0;
  localparam int FE_BIT  = 9;

  //--------------------------------------------------------------------------
  // Writable masks and reset values
  //--------------------------------------------------------------------------
  localparam logic [7:0] SPC_TXCS_WMASK = 8'hFD;
  localparam logic [7:0] SPC_RXCS_WMASK = 8'hF8;
  localparam logic [7:0] SPC_BC_WMASK   = 8'h1B;
  localparam logic [7:0] SPC_CTRL_RST   = 8'h00;
  localparam logic       SPC_EMPTY_RST  = 1'b1;
  localparam logic       SPC_IDLE_RST   = 1'b1;
  localparam logic [1:0] SPC_FIFO_DEPTH = 2'h2;

endpackage : spc_pkg

// >>> hdl/spc_regs.sv
// Control and status registers of the serial port, with receive FIFO
//
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
module spc_regs (
  input  wire logic        clock,
  input  wire logic        rst,
  // Wishbone classic slave
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [31:0] wb_dat_w,
  input  wire logic [3:0]  wb_sel,
  output logic      [31:0] wb_dat_r,
  output logic             wb_ack,
  // Events and status from the shifting datapath
  input  wire logic        tx_shift_full,
  input  wire logic        break_done,
  input  wire logic        rx_start,
  input  wire logic        rx_char_strobe,
  input  wire logic [8:0]  rx_char_data,
  input  wire logic        rx_char_frame_err,
  input  wire logic        rx_edge,
  input  wire logic        autobaud_done,
  input  wire logic        autobaud_overflow,
  // Controls towards the datapath
  output logic             port_enable,
  output logic             sync_mode,
  output logic             clock_master,
  output logic             tx_enable,
  output logic             tx_nine_bit,
  output logic             tx_ninth_data,
  output logic             send_break,
  output logic             high_baud,
  output logic             rx_enable,
  output logic             rx_nine_bit,
  output logic             tx_invert,
  output logic             sync_clock_rising,
  output logic             wake_wait,
  output logic             autobaud_run,
  output logic             baud_tick,
  output logic             receive_pending_flag
);
  import spc_pkg::*;

  //--------------------------------------------------------------------------
  // Declarations
  //--------------------------------------------------------------------------
  logic [7:0]  txcs_q;
  logic [7:0]  rxcs_q;
  logic [7:0]  bc_q;
  logic [7:0]  divl_q;
  logic [7:0]  divh_q;
  logic        shift_empty_q;
  logic        idle_q;
  logic        overrun_error_flag_q;
  logic        abd_ovf_q;
  logic        wake_q;
  logic [9:0]  fifo_q [2];
  logic        rd_ptr_q;
  logic        wr_ptr_q;
  logic [1:0]  fifo_cnt_q;
  logic [15:0] baud_cnt_q;
  logic        tick_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic [31:0] rd_mux;
  logic        req;
  logic        wr_en;
  logic        rd_en;
  logic        wr_tx;
  logic        wr_rx;
  logic        wr_bc;
  logic        wr_dl;
  logic        wr_dh;
  logic        port_on;
  logic        sync;
  logic        master;
  logic        cont_rx;
  logic        single_rx;
  logic        rx_on;
  logic        filter;
  logic        accept;
  logic        full;
  logic        pop;
  logic        push;
  logic        ovr_set;
  logic        single_done;
  logic        wake_hit;
  logic [9:0]  head;
  logic [15:0] reload;

  //--------------------------------------------------------------------------
  // Address decode helper
  //--------------------------------------------------------------------------
  // Word aligned match; the two low address bits are ignored
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction : hit

  //--------------------------------------------------------------------------
  // Bus strobes
  //--------------------------------------------------------------------------
  // Access is taken in the cycle before ack, so ack follows one edge later
  assign req   = wb_cyc & wb_stb & ~ack_q;
  assign wr_en = req & wb_we & wb_sel[0];
  assign rd_en = req & ~wb_we;
  assign wr_tx = wr_en & hit(wb_adr, SPC_OFF_TXCS);
  assign wr_rx = wr_en & hit(wb_adr, SPC_OFF_RXCS);
  assign wr_bc = wr_en & hit(wb_adr, SPC_OFF_BC);
  assign wr_dl = wr_en & hit(wb_adr, SPC_OFF_DIVL);
  assign wr_dh = wr_en & hit(wb_adr, SPC_OFF_DIVH);

  //--------------------------------------------------------------------------
  // Mode decode
  //--------------------------------------------------------------------------
  // Port enable gates only rx_on below; the other mode bits are raw register bits
  assign port_on   = rxcs_q[RX_PORT_EN];
  assign sync      = txcs_q[TX_SYNC];
  assign master    = sync & txcs_q[TX_CLKSRC];
  assign cont_rx   = rxcs_q[RX_CONT];
  assign single_rx = rxcs_q[RX_SINGLE];
  // Single receive only counts for a sync master
  assign rx_on  = port_on & (cont_rx | (master & single_rx));
  assign filter = rxcs_q[RX_NINE] & rxcs_q[RX_ADEN] & ~sync;
  assign head   = fifo_q[rd_ptr_q];

  //--------------------------------------------------------------------------
  // Receive acceptance
  //--------------------------------------------------------------------------
  // While waiting for a wake edge no character is taken
  assign wake_wait = port_on & ~sync & bc_q[BC_WAKE];
  assign wake_hit  = wake_wait & rx_edge;
  // Overrun blocks further characters until it is cleared
  assign accept    = rx_char_strobe & rx_on & ~overrun_error_flag_q & ~wake_wait
                     & (~filter | rx_char_data[8]);
  assign full      = fifo_cnt_q == SPC_FIFO_DEPTH;
  assign pop       = rd_en & hit(wb_adr, SPC_OFF_RDAT)
                     & (fifo_cnt_q != 2'h0);
  // A read in the same cycle frees a slot for the arriving character
  assign push      = accept & (~full | pop);
  assign ovr_set   = accept & full & ~pop;
  // Continuous receive overrides single receive
  assign single_done = rx_char_strobe & port_on & master & single_rx
                       & ~cont_rx;

  //--------------------------------------------------------------------------
  // Transmit control and status
  //--------------------------------------------------------------------------
  // A software write wins over the hardware break clear
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      txcs_q <= SPC_CTRL_RST;
    else if (wr_tx)
      txcs_q <= wb_dat_w[7:0] & SPC_TXCS_WMASK;
    else if (break_done & ~sync)
      txcs_q[TX_BRK] <= 1'b0;
  end

  // Shift register empty flag follows the datapath
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      shift_empty_q <= SPC_EMPTY_RST;
    else
      shift_empty_q <= ~port_on | ~tx_shift_full;
  end

  //--------------------------------------------------------------------------
  // Receive control
  //--------------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      rxcs_q <= SPC_CTRL_RST;
    else if (wr_rx)
      rxcs_q <= wb_dat_w[7:0] & SPC_RXCS_WMASK;
    else if (single_done)
      rxcs_q[RX_SINGLE] <= 1'b0;
  end

  // Overrun: set wins over the clear by continuous receive off
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      overrun_error_flag_q <= 1'b0;
    else if (ovr_set)
      overrun_error_flag_q <= 1'b1;
    else if (~cont_rx | ~port_on)
      overrun_error_flag_q <= 1'b0;
  end

  //--------------------------------------------------------------------------
  // Baud control
  //--------------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      bc_q <= SPC_CTRL_RST;
    else if (wr_bc)
      bc_q <= wb_dat_w[7:0] & SPC_BC_WMASK;
    else
    begin
      if (wake_hit)
        bc_q[BC_WAKE] <= 1'b0;
      if (autobaud_done & ~sync)
        bc_q[BC_ABD] <= 1'b0;
    end
  end

  // Overflow is set by the timer, dropped when detection restarts
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      abd_ovf_q <= 1'b0;
    else if (autobaud_overflow & port_on & ~sync)
      abd_ovf_q <= 1'b1;
    else if (~port_on | (wr_bc & wb_dat_w[BC_ABD]))
      abd_ovf_q <= 1'b0;
  end

  // Idle from reset; busy from start bit to end of character
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      idle_q <= SPC_IDLE_RST;
    else if (~port_on)
      idle_q <= 1'b1;
    else if (rx_start & ~sync)
      idle_q <= 1'b0;
    else if (rx_char_strobe)
      idle_q <= 1'b1;
  end

  // Wake event counts as pending until the data register is read
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      wake_q <= 1'b0;
    else if (wake_hit)
      wake_q <= 1'b1;
    else if (~port_on | (rd_en & hit(wb_adr, SPC_OFF_RDAT)))
      wake_q <= 1'b0;
  end

  //--------------------------------------------------------------------------
  // Receive FIFO, two characters with their framing bits
  //--------------------------------------------------------------------------
  // Each entry keeps its framing bit so the flag tracks the top entry
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      fifo_q[0] <= 10'h000;
      fifo_q[1] <= 10'h000;
    end
    else if (push)
      fifo_q[wr_ptr_q] <= {rx_char_frame_err,
                           rx_char_data[8] & rxcs_q[RX_NINE],
                           rx_char_data[7:0]};
  end

  // Pointers and count; port disable empties the FIFO
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rd_ptr_q   <= 1'b0;
      wr_ptr_q   <= 1'b0;
      fifo_cnt_q <= 2'h0;
    end
    else if (~port_on)
    begin
      rd_ptr_q   <= 1'b0;
      wr_ptr_q   <= 1'b0;
      fifo_cnt_q <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= ~wr_ptr_q;
      if (pop)
        rd_ptr_q <= ~rd_ptr_q;
      if (push & ~pop)
        fifo_cnt_q <= fifo_cnt_q + 2'h1;
      else if (pop & ~push)
        fifo_cnt_q <= fifo_cnt_q - 2'h1;
    end
  end

  //--------------------------------------------------------------------------
  // Baud generator
  //--------------------------------------------------------------------------
  // Narrow mode ignores the high divisor byte
  assign reload = bc_q[BC_WIDE] ? {divh_q, divl_q} : {8'h00, divl_q};

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      divl_q <= SPC_CTRL_RST;
      divh_q <= SPC_CTRL_RST;
    end
    else
    begin
      if (wr_dl)
        divl_q <= wb_dat_w[7:0];
      if (wr_dh)
        divh_q <= wb_dat_w[7:0];
    end
  end

  // Divisor writes restart the count so a new rate takes hold at once
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      baud_cnt_q <= 16'h0000;
      tick_q     <= 1'b0;
    end
    else if (~port_on | wr_dl | wr_dh)
    begin
      baud_cnt_q <= 16'h0000;
      tick_q     <= 1'b0;
    end
    else if (baud_cnt_q == 16'h0000)
    begin
      baud_cnt_q <= reload;
      tick_q     <= 1'b1;
    end
    else
    begin
      baud_cnt_q <= baud_cnt_q - 16'h0001;
      tick_q <= 1'b0;
    end
  end

  //--------------------------------------------------------------------------
  // Read mux and bus answer
  //--------------------------------------------------------------------------
  // Unmapped addresses answer with zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit(wb_adr, SPC_OFF_TXCS))
      rd_mux[7:0] = {txcs_q[7:2], shift_empty_q, txcs_q[TX_D9]};
    else if (hit(wb_adr, SPC_OFF_RXCS))
      rd_mux[7:0] = {rxcs_q[7:3], head[FE_BIT] & (fifo_cnt_q != 2'h0),
                     overrun_error_flag_q, head[8]};
    else if (hit(wb_adr, SPC_OFF_BC))
      rd_mux[7:0] = {abd_ovf_q, idle_q, 1'b0, bc_q[BC_POL],
                     bc_q[BC_WIDE], 1'b0, bc_q[BC_WAKE], bc_q[BC_ABD]};
    else if (hit(wb_adr, SPC_OFF_RDAT))
      rd_mux[7:0] = head[7:0];
    else if (hit(wb_adr, SPC_OFF_DIVL))
      rd_mux[7:0] = divl_q;
    else if (hit(wb_adr, SPC_OFF_DIVH))
      rd_mux[7:0] = divh_q;
    else if (hit(wb_adr, SPC_OFF_STAT))
      rd_mux[0] = receive_pending_flag;
  end

  // One ack per request; it drops the cycle after it is given
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req;
      if (rd_en)
        rdat_q <= rd_mux;
    end
  end

  //--------------------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------------------
  assign wb_ack            = ack_q;
  assign wb_dat_r          = rdat_q;
  assign port_enable       = port_on;
  assign sync_mode         = port_on & sync;
  assign clock_master      = port_on & master;
  // Either receive enable steals the line in sync mode
  assign tx_enable         = port_on & txcs_q[TX_EN]
                             & ~(sync & (single_rx | cont_rx));
  assign tx_nine_bit       = txcs_q[TX_NINE];
  assign tx_ninth_data     = txcs_q[TX_D9];
  assign send_break        = port_on & ~sync & txcs_q[TX_BRK];
  assign high_baud         = ~sync & txcs_q[TX_HIBAUD];
  assign rx_enable         = rx_on & ~wake_wait;
  assign rx_nine_bit       = rxcs_q[RX_NINE];
  assign tx_invert         = ~sync & bc_q[BC_POL];
  assign sync_clock_rising = sync & bc_q[BC_POL];
  assign autobaud_run      = port_on & ~sync & bc_q[BC_ABD];
  assign baud_tick         = tick_q;
  // Hardware only; software clears it only by reading the data register or turning receive off
  assign receive_pending_flag = (rx_on & (fifo_cnt_q != 2'h0))
                                | wake_q;

  //--------------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  ack_pulse_a: assert property (wb_ack |=> !wb_ack)
    else $error("ack held longer than one cycle");
  overrun_clear_a: assert property
    ((!cont_rx && !ovr_set) |=> !overrun_error_flag_q)
    else $error("overrun flag survived receive disable");
  overrun_set_a: assert property
    ((accept && full && !pop) |=> (overrun_error_flag_q && fifo_cnt_q == 2'h2))
    else $error("third character did not raise overrun");
  pending_push_a: assert property
    ((push && rx_on && !wr_rx && !single_done) |=> receive_pending_flag)
    else $error("pending flag missing after character stored");
  addr_filter_a: assert property
    ((rx_char_strobe && filter && !rx_char_data[8] && !pop && port_on)
     |=> fifo_cnt_q == $past(fifo_cnt_q))
    else $error("address filter let a data character through");
  shift_empty_a: assert property
    ((port_on && !tx_shift_full) |=> shift_empty_q)
    else $error("shift empty flag not set");
  idle_start_a: assert property
    ((port_on && !sync && rx_start && !wr_rx) |=> !idle_q)
    else $error("idle flag did not drop on start bit");
  wake_clear_a: assert property
    ((wake_hit && !wr_bc) |=> (!bc_q[BC_WAKE] && receive_pending_flag))
    else $error("wake enable did not clear itself");
  break_clear_a: assert property
    ((break_done && !sync && !wr_tx) |=> !send_break)
    else $error("break request not cleared on completion");
  sync_tx_block_a: assert property
    ((sync && (single_rx || cont_rx)) |-> !tx_enable)
    else $error("transmitter active while sync receive enabled");
  port_reset_a: assert property
    ((!port_on && !wr_rx) |=> (fifo_cnt_q == 2'h0 && idle_q && !overrun_error_flag_q))
    else $error("port not held in reset while disabled");

  char_stored_c: cover property (push ##1 pop);
  overrun_c:     cover property (ovr_set);
  wake_c:        cover property (wake_hit);
  addr_skip_c:   cover property (rx_char_strobe && filter && !accept);

endmodule : spc_regs

// >>> verification/spc_line_model.sv
// Behavioural model of the shifting datapath facing the register set
module spc_line_model (
  input  wire logic       clock,
  output logic            tx_shift_full,
  output logic            break_done,
  output logic            rx_start,
  output logic            rx_char_strobe,
  output logic [8:0]      rx_char_data,
  output logic            rx_char_frame_err,
  output logic            rx_edge,
  output logic            autobaud_done,
  output logic            autobaud_overflow
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet line at start; data bus shows a pattern, not a held value
  initial
  begin
    {tx_shift_full, break_done, rx_start, rx_char_strobe} = 4'h0;
    {rx_edge, autobaud_done, autobaud_overflow} = 3'h0;
    rx_char_data = 9'h1AA;
    rx_char_frame_err = 1'b0;
  end
  // One finished character; data inverted after the strobe
  task automatic send_char(input logic [8:0] d, input logic fe);
    @(posedge clock);
    rx_start <= 1'b1;
    @(posedge clock);
    rx_start <= 1'b0;
    rx_char_strobe <= 1'b1;
    rx_char_data <= d;
    rx_char_frame_err <= fe;
    @(posedge clock);
    rx_char_strobe <= 1'b0;
    rx_char_data <= ~d;
    rx_char_frame_err <= ~fe;
  endtask : send_char
  // One-cycle event: 0 break finished, 1 falling edge on the line
  task automatic pulse(input int k);
    @(posedge clock);
    if (k == 0) break_done <= 1'b1;
    else rx_edge <= 1'b1;
    @(posedge clock);
    break_done <= 1'b0;
    rx_edge <= 1'b0;
  endtask : pulse
endmodule : spc_line_model

// >>> verification/serial_port_control_regs_tb.sv
// Self-checking bench for the serial port register set
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  miscompares++; $display("ERROR %0t: got %h want %h", $time, a, b); end end
module serial_port_control_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import spc_pkg::*;
  logic clock = 1'b0, rst = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat_w = 32'h0, wb_dat_r;
  logic [3:0] wb_sel = 4'h0;
  logic wb_ack, tsf, brk, rxs, rcs, rfe, edg, abd, abo, sbrk, hib, pend;
  logic [8:0] rcd;
  logic [7:0] q;
  int miscompares = 0, samples_checked = 0;
  //--------------------------------------------------------------------------
  // Instances
  //--------------------------------------------------------------------------
  spc_regs i_dut (.clock(clock), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_dat_w(wb_dat_w), .wb_sel(wb_sel),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .tx_shift_full(tsf),
    .break_done(brk), .rx_start(rxs), .rx_char_strobe(rcs),
    .rx_char_data(rcd), .rx_char_frame_err(rfe), .rx_edge(edg),
    .autobaud_done(abd), .autobaud_overflow(abo), .port_enable(),
    .sync_mode(), .clock_master(), .tx_enable(), .tx_nine_bit(),
    .tx_ninth_data(), .send_break(sbrk), .high_baud(hib), .rx_enable(),
    .rx_nine_bit(), .tx_invert(), .sync_clock_rising(), .wake_wait(),
    .autobaud_run(), .baud_tick(), .receive_pending_flag(pend));
  spc_line_model i_line (.clock(clock), .tx_shift_full(tsf),
    .break_done(brk), .rx_start(rxs), .rx_char_strobe(rcs),
    .rx_char_data(rcd), .rx_char_frame_err(rfe), .rx_edge(edg),
    .autobaud_done(abd), .autobaud_overflow(abo));
  // Clock of 40 ns period
  always #20 clock = ~clock;
  //--------------------------------------------------------------------------
  // Bus cycle and verdict
  //--------------------------------------------------------------------------
  // Classic cycle held until ack is sampled; waits are bounded
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel} <= {2'h3, we, a, 4'hF};
    wb_dat_w <= {24'h0, d};
    do
    begin
      @(posedge clock);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 50);
    q = wb_dat_r[7:0];
    if (n >= 50) miscompares++;
    {wb_cyc, wb_stb} <= 2'h0;
  endtask : wb
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  //--------------------------------------------------------------------------
  // Scenarios
  //--------------------------------------------------------------------------
  task automatic t_reset();
    wb(0, SPC_OFF_TXCS, 8'h00); `CHK(q, 8'h02)
    wb(0, SPC_OFF_BC, 8'h00); `CHK(q, 8'h40)
    wb(0, 8'h1C, 8'h00); `CHK(q, 8'h00)
  endtask : t_reset
  // Break acts only in async mode with the port on, high speed in async mode
  task automatic t_break();
    wb(1, SPC_OFF_RXCS, 8'h80);
    wb(1, SPC_OFF_TXCS, 8'h0C);
    @(negedge clock); `CHK({sbrk, hib}, 2'h3)
    i_line.pulse(0);
    wb(0, SPC_OFF_TXCS, 8'h00); `CHK(q, 8'h06)
    wb(1, SPC_OFF_TXCS, 8'h1C);
    @(negedge clock); `CHK({sbrk, hib}, 2'h0)
  endtask : t_break
  // Nine-bit character with framing error, then popped
  task automatic t_rx();
    wb(1, SPC_OFF_TXCS, 8'h00);
    wb(1, SPC_OFF_RXCS, 8'hD0);
    i_line.send_char(9'h155, 1'b1);
    @(negedge clock); `CHK(pend, 1'b1)
    wb(0, SPC_OFF_RXCS, 8'h00); `CHK(q, 8'hD5)
    wb(0, SPC_OFF_RDAT, 8'h00); `CHK(q, 8'h55)
    @(negedge clock); `CHK(pend, 1'b0)
  endtask : t_rx
  // Third character overruns the two-deep FIFO
  task automatic t_overrun();
    repeat (3) i_line.send_char(9'h011, 1'b0);
    wb(0, SPC_OFF_RXCS, 8'h00); `CHK(q, 8'hD2)
    wb(1, SPC_OFF_RXCS, 8'hC0);
    wb(0, SPC_OFF_RXCS, 8'h00); `CHK(q, 8'hC0)
    @(negedge clock); `CHK(pend, 1'b0)
  endtask : t_overrun
  // Falling edge while waiting sets pending and clears the enable
  task automatic t_wake();
    wb(1, SPC_OFF_RXCS, 8'h00);
    wb(1, SPC_OFF_RXCS, 8'h90);
    wb(1, SPC_OFF_BC, 8'h02);
    i_line.pulse(1);
    wb(0, SPC_OFF_BC, 8'h00); `CHK(q, 8'h40)
    @(negedge clock); `CHK(pend, 1'b1)
  endtask : t_wake
  // Address filter drops a data character, keeps an address one
  task automatic t_addr();
    wb(1, SPC_OFF_RXCS, 8'h00);
    wb(1, SPC_OFF_RXCS, 8'hD8);
    i_line.send_char(9'h011, 1'b0);
    @(negedge clock); `CHK(pend, 1'b0)
    i_line.send_char(9'h1AB, 1'b0);
    wb(0, SPC_OFF_RXCS, 8'h00); `CHK(q, 8'hD9)
    wb(0, SPC_OFF_RDAT, 8'h00); `CHK(q, 8'hAB)
  endtask : t_addr
  //--------------------------------------------------------------------------
  // Main sequence and watchdog
  //--------------------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_break();
    t_rx();
    t_overrun();
    t_wake();
    t_addr();
    final_report();
  end
  // Whole run is about a hundred cycles; this 5000-cycle limit is far beyond it
  initial
  begin
    #200000;
    miscompares++;
    final_report();
  end
endmodule : serial_port_control_regs_tb
